// >>> weigh_regs_pkg.sv
package weigh_regs_pkg;
   // register numbers as seen on the register port
   localparam logic [15:0] ADDR_GROSS_HIGH   = 16'h7531;
   localparam logic [15:0] ADDR_GROSS_LOW    = 16'h7532;
   localparam logic [15:0] ADDR_NET_HIGH     = 16'h7533;
   localparam logic [15:0] ADDR_NET_LOW      = 16'h7534;
   localparam logic [15:0] ADDR_INPUT_STATUS = 16'h7535;
   localparam logic [15:0] ADDR_CMD_STATUS   = 16'h7536;
   localparam logic [15:0] ADDR_OUT_STATUS   = 16'h7537;
   localparam logic [15:0] ADDR_MICROVOLTS   = 16'h759F;
   localparam logic [15:0] ADDR_CMD_CODE     = 16'h9C41;
   localparam logic [15:0] ADDR_ARG1_HIGH    = 16'h9C42;
   localparam logic [15:0] ADDR_ARG1_LOW     = 16'h9C43;
   localparam logic [15:0] ADDR_ARG2_HIGH    = 16'h9C44;
   localparam logic [15:0] ADDR_ARG2_LOW     = 16'h9C45;

   // input status word fields
   localparam int BIT_NET_SIGN    = 0;
   localparam int BIT_GROSS_SIGN  = 1;
   localparam int BIT_STABLE      = 2;
   localparam int BIT_UNDERLOAD   = 3;
   localparam int BIT_OVERLOAD    = 4;
   localparam int BIT_PRESET_TARE = 5;
   localparam int BIT_DIN1        = 8;
   localparam int BIT_DIN2        = 9;
   localparam int BIT_CHAN_LSB    = 14;

   // output status word fields
   localparam int BIT_DOUT2 = 0;
   localparam int BIT_DOUT1 = 1;

   // command status word fields
   localparam int CSTAT_COUNT_LSB  = 0;
   localparam int CSTAT_RESULT_LSB = 4;
   localparam int CSTAT_CODE_LSB   = 8;

   // command codes
   localparam logic [7:0] CMD_NONE       = 8'h00;
   localparam logic [7:0] CMD_ZERO       = 8'h01;
   localparam logic [7:0] CMD_TARE       = 8'h02;
   localparam logic [7:0] CMD_PRESET     = 8'h03;
   localparam logic [7:0] CMD_SETPOINT1  = 8'h0A;
   localparam logic [7:0] CMD_SETPOINT2  = 8'h0B;
   localparam logic [7:0] CMD_DOUT       = 8'h19;
   localparam logic [7:0] CMD_REBOOT     = 8'h22;

   // result reported for a code the device does not know
   localparam logic [3:0] RESULT_BAD_CODE = 4'hF;
   // reset word and the fixed active channel reported in the status word
   localparam logic [15:0] RST_WORD   = 16'h0000;
   localparam logic [1:0]  ACTIVE_CHAN = 2'h0;
endpackage : weigh_regs_pkg

// >>> pin_sync.sv
`timescale 1ns/1ps
// three-stage synchroniser per bit; the output follows once stages two
// and three agree, so a single-cycle glitch past stage one is ignored
module pin_sync #(
   parameter int WIDTH = 2
) (
   input  wire logic             i_clk,
   input  wire logic             i_rst,
   input  wire logic             i_ce,
   input  wire logic [WIDTH-1:0] i_pin,
   output logic      [WIDTH-1:0] o_level
);
   genvar g;
   generate
      for (g = 0; g < WIDTH; g++) begin : g_bit
         logic meta_reg;
         logic s2_reg;
         logic s3_reg;
         logic level_reg;
         // one process per bit owns its own level; the port only gathers
         assign o_level[g] = level_reg;
         // stage one is read by stage two only
         always_ff @(posedge i_clk or posedge i_rst) begin
            if (i_rst) begin
               meta_reg   <= 1'b0;
               s2_reg     <= 1'b0;
               s3_reg     <= 1'b0;
               level_reg  <= 1'b0;
            end else if (i_ce) begin
               meta_reg <= i_pin[g];
               s2_reg   <= meta_reg;
               s3_reg   <= s2_reg;
               if (s2_reg == s3_reg) begin
                  level_reg <= s3_reg;
               end
            end
         end
      end
   endgenerate
endmodule : pin_sync

// >>> weigh_regs.sv
`timescale 1ns/1ps
// Overview of operation
// [RQ1] status bit 5 is one while a preset tare is active
// [RQ2] status bit 4 reports overload, one when overloaded
// [RQ3] status bit 3 reports underload, one when underloaded
// [RQ4] status stability bit reads one when stable, zero when unstable
// [RQ5] status bit 1 is gross weight sign, one when negative
// [RQ6] status bit 0 is net weight sign, one when negative
// [RQ7] status bits 9 and 8 mirror digital inputs two and one
// [RQ8] output word: bit 1 output one, bit 0 output two, rest zero
// [RQ9] command register accepts codes 00,01,02,03,0A,0B,19,22 hex
// [RQ10] master writes arguments as unsigned magnitudes in two word pairs
// [RQ11] master writes arguments first, then the command code
// [RQ12] after a command, status shows code, result and bumped count
module weigh_regs (
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   input  wire logic        i_ce,
   // register port
   input  wire logic [15:0] i_reg_addr,
   input  wire logic        i_reg_rd,
   input  wire logic        i_reg_wr,
   input  wire logic [15:0] i_reg_wdata,
   output logic      [15:0] o_reg_rdata,
   output logic             o_reg_ack,
   output logic             o_reg_err,
   // measurement state from the weighing core
   input  wire logic [31:0] i_gross_weight,
   input  wire logic [31:0] i_net_weight,
   input  wire logic [15:0] i_microvolts,
   input  wire logic        i_preset_tare_flag,
   input  wire logic        i_overload,
   input  wire logic        i_underload,
   input  wire logic        i_stable,
   input  wire logic [1:0]  i_din_pin,
   input  wire logic [1:0]  i_dout_state,
   // command hand-off to the weighing core
   output logic             o_cmd_valid,
   output logic      [7:0]  o_cmd_code,
   output logic      [31:0] o_cmd_arg1,
   output logic      [31:0] o_cmd_arg2,
   input  wire logic        i_cmd_done,
   input  wire logic [3:0]  i_cmd_result
);
   typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_WAIT} cmd_state_t;

   cmd_state_t  state_reg;
   logic [15:0] cmd_code_reg;
   logic [15:0] arg1_high_reg;
   logic [15:0] arg1_low_reg;
   logic [15:0] arg2_high_reg;
   logic [15:0] arg2_low_reg;
   logic [7:0]  last_code_reg;
   logic [3:0]  last_result_reg;
   logic [3:0]  count_reg;
   logic [1:0]  din_level;
   logic [15:0] input_status;
   logic [15:0] output_status;
   logic [15:0] cmd_status;
   logic [15:0] rd_value;
   logic        rd_hit;
   logic        wr_hit;
   logic        cmd_write;
   logic        code_known;

   // inputs arrive from pins, so they are synchronised first
   pin_sync #(.WIDTH(2)) u_din_sync (
      .i_clk   (i_clk),
      .i_rst   (i_rst),
      .i_ce    (i_ce),
      .i_pin   (i_din_pin),
      .o_level (din_level)
   );

   // input status word assembly
   always_comb begin
      input_status = weigh_regs_pkg::RST_WORD;
      // [RQ6] net sign bit
      input_status[weigh_regs_pkg::BIT_NET_SIGN]    = i_net_weight[31];
      // [RQ5] gross sign bit
      input_status[weigh_regs_pkg::BIT_GROSS_SIGN]  = i_gross_weight[31];
      // [RQ4] stability flag
      input_status[weigh_regs_pkg::BIT_STABLE]      = i_stable;
      // [RQ3] underload flag
      input_status[weigh_regs_pkg::BIT_UNDERLOAD]   = i_underload;
      // [RQ2] overload flag
      input_status[weigh_regs_pkg::BIT_OVERLOAD]    = i_overload;
      // [RQ1] preset tare flag
      input_status[weigh_regs_pkg::BIT_PRESET_TARE] = i_preset_tare_flag;
      // [RQ7] digital input mirror
      input_status[weigh_regs_pkg::BIT_DIN1]        = din_level[0];
      input_status[weigh_regs_pkg::BIT_DIN2]        = din_level[1];
      input_status[weigh_regs_pkg::BIT_CHAN_LSB +: 2] =
         weigh_regs_pkg::ACTIVE_CHAN;
   end

   // output and command status words
   always_comb begin
      output_status = weigh_regs_pkg::RST_WORD;
      // [RQ8] output one on bit 1, two on bit 0
      output_status[weigh_regs_pkg::BIT_DOUT1] = i_dout_state[0];
      output_status[weigh_regs_pkg::BIT_DOUT2] = i_dout_state[1];
      cmd_status = {last_code_reg, last_result_reg, count_reg};
   end

   // read mux; unmapped numbers answer with an error and zero data
   always_comb begin
      rd_hit = 1'b1;
      case (i_reg_addr)
         weigh_regs_pkg::ADDR_GROSS_HIGH:   rd_value = i_gross_weight[31:16];
         weigh_regs_pkg::ADDR_GROSS_LOW:    rd_value = i_gross_weight[15:0];
         weigh_regs_pkg::ADDR_NET_HIGH:     rd_value = i_net_weight[31:16];
         weigh_regs_pkg::ADDR_NET_LOW:      rd_value = i_net_weight[15:0];
         weigh_regs_pkg::ADDR_INPUT_STATUS: rd_value = input_status;
         weigh_regs_pkg::ADDR_CMD_STATUS:   rd_value = cmd_status;
         weigh_regs_pkg::ADDR_OUT_STATUS:   rd_value = output_status;
         weigh_regs_pkg::ADDR_MICROVOLTS:   rd_value = i_microvolts;
         weigh_regs_pkg::ADDR_CMD_CODE:     rd_value = cmd_code_reg;
         weigh_regs_pkg::ADDR_ARG1_HIGH:    rd_value = arg1_high_reg;
         weigh_regs_pkg::ADDR_ARG1_LOW:     rd_value = arg1_low_reg;
         weigh_regs_pkg::ADDR_ARG2_HIGH:    rd_value = arg2_high_reg;
         weigh_regs_pkg::ADDR_ARG2_LOW:     rd_value = arg2_low_reg;
         default: begin
            rd_value = weigh_regs_pkg::RST_WORD;
            rd_hit   = 1'b0;
         end
      endcase
   end

   // writes land only on holding registers; any write while a command
   // is in flight is refused so arguments cannot change under the core
   always_comb begin
      cmd_write = (i_reg_addr == weigh_regs_pkg::ADDR_CMD_CODE);
      wr_hit = (i_reg_addr >= weigh_regs_pkg::ADDR_CMD_CODE) &&
               (i_reg_addr <= weigh_regs_pkg::ADDR_ARG2_LOW) &&
               (state_reg == ST_IDLE);
   end

   // [RQ9] recognised command codes
   always_comb begin
      case (cmd_code_reg[7:0])
         weigh_regs_pkg::CMD_ZERO,
         weigh_regs_pkg::CMD_TARE,
         weigh_regs_pkg::CMD_PRESET,
         weigh_regs_pkg::CMD_SETPOINT1,
         weigh_regs_pkg::CMD_SETPOINT2,
         weigh_regs_pkg::CMD_DOUT,
         weigh_regs_pkg::CMD_REBOOT: begin
            code_known = (cmd_code_reg[15:8] == 8'h00);
         end
         default:                    code_known = 1'b0;
      endcase
   end

   // register port answer, one cycle after the strobe
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_reg_rdata <= weigh_regs_pkg::RST_WORD;
         o_reg_ack   <= 1'b0;
         o_reg_err   <= 1'b0;
      end else if (i_ce) begin
         o_reg_ack <= i_reg_rd | i_reg_wr;
         o_reg_err <= (i_reg_rd & ~rd_hit) | (i_reg_wr & ~wr_hit);
         if (i_reg_rd) begin
            o_reg_rdata <= rd_value;
         end
      end
   end

   // holding registers
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         cmd_code_reg  <= weigh_regs_pkg::RST_WORD;
         arg1_high_reg <= weigh_regs_pkg::RST_WORD;
         arg1_low_reg  <= weigh_regs_pkg::RST_WORD;
         arg2_high_reg <= weigh_regs_pkg::RST_WORD;
         arg2_low_reg  <= weigh_regs_pkg::RST_WORD;
      end else if (i_ce && i_reg_wr && wr_hit) begin
         case (i_reg_addr)
            weigh_regs_pkg::ADDR_CMD_CODE:  cmd_code_reg  <= i_reg_wdata;
            weigh_regs_pkg::ADDR_ARG1_HIGH: arg1_high_reg <= i_reg_wdata;
            weigh_regs_pkg::ADDR_ARG1_LOW:  arg1_low_reg  <= i_reg_wdata;
            weigh_regs_pkg::ADDR_ARG2_HIGH: arg2_high_reg <= i_reg_wdata;
            weigh_regs_pkg::ADDR_ARG2_LOW:  arg2_low_reg  <= i_reg_wdata;
            default: ;
         endcase
      end
   end

   // command sequencer: a nonzero code write starts it, the core's done
   // (or an unknown code) closes it
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         state_reg       <= ST_IDLE;
         o_cmd_valid     <= 1'b0;
         o_cmd_code      <= 8'h00;
         o_cmd_arg1      <= 32'h0000_0000;
         o_cmd_arg2      <= 32'h0000_0000;
         last_code_reg   <= 8'h00;
         last_result_reg <= 4'h0;
         count_reg       <= 4'h0;
      end else if (i_ce) begin
         o_cmd_valid <= 1'b0;
         case (state_reg)
            ST_IDLE: begin
               if (i_reg_wr && wr_hit && cmd_write &&
                   i_reg_wdata != weigh_regs_pkg::RST_WORD) begin
                  state_reg <= ST_ISSUE;
               end
            end
            ST_ISSUE: begin
               if (code_known) begin
                  // [RQ10] arguments passed as unsigned magnitudes
                  o_cmd_valid <= 1'b1;
                  o_cmd_code  <= cmd_code_reg[7:0];
                  o_cmd_arg1  <= {arg1_high_reg, arg1_low_reg};
                  o_cmd_arg2  <= {arg2_high_reg, arg2_low_reg};
                  state_reg   <= ST_WAIT;
               end else begin
                  // [RQ12] unknown code still reported
                  last_code_reg   <= cmd_code_reg[7:0];
                  last_result_reg <= weigh_regs_pkg::RESULT_BAD_CODE;
                  count_reg       <= count_reg + 4'h1;
                  state_reg       <= ST_IDLE;
               end
            end
            ST_WAIT: begin
               if (i_cmd_done) begin
                  // [RQ12] completion update
                  last_code_reg   <= o_cmd_code;
                  last_result_reg <= i_cmd_result;
                  count_reg       <= count_reg + 4'h1;
                  state_reg       <= ST_IDLE;
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // checks
   chk_overload_read: assert property ( // [RQ2]
      @(posedge i_clk) disable iff (i_rst)
      (i_ce && i_reg_rd && i_reg_addr == weigh_regs_pkg::ADDR_INPUT_STATUS)
      |=> o_reg_rdata[4] == $past(i_overload) &&
          o_reg_rdata[3] == $past(i_underload))
      else $error("overload or underload bit wrong");
   chk_tare_read: assert property ( // [RQ1]
      @(posedge i_clk) disable iff (i_rst)
      (i_ce && i_reg_rd && i_reg_addr == weigh_regs_pkg::ADDR_INPUT_STATUS)
      |=> o_reg_rdata[5] == $past(i_preset_tare_flag) &&
          o_reg_rdata[2] == $past(i_stable))
      else $error("preset tare or stable bit wrong");
   chk_sign_bits: assert property ( // [RQ5]
      @(posedge i_clk) disable iff (i_rst)
      (i_ce && i_reg_rd && i_reg_addr == weigh_regs_pkg::ADDR_INPUT_STATUS)
      |=> o_reg_rdata[1:0] ==
          {$past(i_gross_weight[31]), $past(i_net_weight[31])})
      else $error("weight sign bits wrong");
   chk_din_mirror: assert property ( // [RQ7]
      @(posedge i_clk) disable iff (i_rst)
      (i_ce && i_reg_rd && i_reg_addr == weigh_regs_pkg::ADDR_INPUT_STATUS)
      |=> o_reg_rdata[9:8] == $past(din_level))
      else $error("digital input bits wrong");
   chk_dout_word: assert property ( // [RQ8]
      @(posedge i_clk) disable iff (i_rst)
      (i_ce && i_reg_rd && i_reg_addr == weigh_regs_pkg::ADDR_OUT_STATUS)
      |=> o_reg_rdata == {14'h0000, $past(i_dout_state[0]),
                          $past(i_dout_state[1])})
      else $error("output status word wrong");
   chk_cmd_issue: assert property ( // [RQ9]
      @(posedge i_clk) disable iff (i_rst)
      (i_ce && state_reg == ST_ISSUE && code_known)
      |=> o_cmd_valid && o_cmd_code == $past(cmd_code_reg[7:0]))
      else $error("known command not issued");
   chk_count_bump: assert property ( // [RQ12]
      @(posedge i_clk) disable iff (i_rst)
      (i_ce && state_reg == ST_WAIT && i_cmd_done)
      |=> count_reg == $past(count_reg) + 4'h1 &&
          last_result_reg == $past(i_cmd_result))
      else $error("command status not updated");
   chk_arg_pack: assert property ( // [RQ10]
      @(posedge i_clk) disable iff (i_rst)
      o_cmd_valid |-> o_cmd_arg1 == {arg1_high_reg, arg1_low_reg} &&
                      o_cmd_arg2 == {arg2_high_reg, arg2_low_reg})
      else $error("argument words misordered");
   cov_preset_cmd: cover property (@(posedge i_clk) disable iff (i_rst)
      o_cmd_valid && o_cmd_code == weigh_regs_pkg::CMD_PRESET);
   cov_bad_code: cover property (@(posedge i_clk) disable iff (i_rst)
      state_reg == ST_ISSUE && !code_known && i_ce);
   cov_unmapped: cover property (@(posedge i_clk) disable iff (i_rst)
      o_reg_ack && o_reg_err);
endmodule : weigh_regs

// >>> core_model.sv
`timescale 1ns/1ps
// weighing core stand-in: takes each command pulse and answers done after
// a delay that depends on the code, so both prompt and slow answers occur
module core_model (
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   input  wire logic        i_cmd_valid,
   input  wire logic [7:0]  i_cmd_code,
   input  wire logic [31:0] i_cmd_arg1,
   input  wire logic [31:0] i_cmd_arg2,
   output logic             o_cmd_done,
   output logic      [3:0]  o_cmd_result,
   output logic      [7:0]  o_seen_code,
   output logic      [31:0] o_seen_arg1,
   output logic      [31:0] o_seen_arg2
);
   logic [3:0] wait_reg;

   // done and result
   // result is only valid with done; otherwise it shows a changed value
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_cmd_done   <= 1'b0;
         o_cmd_result <= 4'h0;
         o_seen_code  <= 8'h00;
         o_seen_arg1  <= 32'h0000_0000;
         o_seen_arg2  <= 32'h0000_0000;
         wait_reg     <= 4'h0;
      end else begin
         o_cmd_done   <= 1'b0;
         o_cmd_result <= ~o_seen_code[3:0];
         if (i_cmd_valid) begin
            o_seen_code <= i_cmd_code;
            o_seen_arg1 <= i_cmd_arg1;
            o_seen_arg2 <= i_cmd_arg2;
            wait_reg    <= {1'b0, i_cmd_code[2:0]} + 4'h1;
         end else if (wait_reg != 4'h0) begin
            wait_reg <= wait_reg - 4'h1;
            if (wait_reg == 4'h1) begin
               o_cmd_done   <= 1'b1;
               o_cmd_result <= o_seen_code[3:0];
            end
         end
      end
   end
endmodule : core_model

// >>> testbench.sv
`timescale 1ns/1ps
module testbench;
   logic        i_clk = 1'b0;
   logic        i_rst = 1'b1;
   logic        i_ce = 1'b1;
   logic [15:0] i_reg_addr = 16'h0000;
   logic        i_reg_rd = 1'b0;
   logic        i_reg_wr = 1'b0;
   logic [15:0] i_reg_wdata = 16'h0000;
   logic [15:0] o_reg_rdata;
   logic        o_reg_ack, o_reg_err;
   logic [31:0] i_gross_weight = 32'h0000_0000;
   logic [31:0] i_net_weight = 32'h0000_0000;
   logic [15:0] i_microvolts = 16'h0000;
   logic        i_preset_tare_flag = 1'b0;
   logic        i_overload = 1'b0;
   logic        i_underload = 1'b0;
   logic        i_stable = 1'b0;
   logic [1:0]  i_din_pin = 2'b00;
   logic [1:0]  i_dout_state = 2'b00;
   logic        o_cmd_valid, i_cmd_done;
   logic [7:0]  o_cmd_code, seen_code;
   logic [31:0] o_cmd_arg1, o_cmd_arg2, seen_arg1, seen_arg2;
   logic [3:0]  i_cmd_result;
   logic [15:0] got_data;
   logic        got_err;
   logic [3:0]  cmd_count = 4'h0;
   int          fail_count = 0;
   int          check_count = 0;
   int          cycles = 0;
   logic [7:0]  codes [8] = '{8'h01, 8'h02, 8'h03, 8'h0A,
                               8'h0B, 8'h19, 8'h22, 8'h55};

   weigh_regs weigh_regs_inst (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce),
      .i_reg_addr(i_reg_addr), .i_reg_rd(i_reg_rd), .i_reg_wr(i_reg_wr),
      .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
      .o_reg_ack(o_reg_ack), .o_reg_err(o_reg_err),
      .i_gross_weight(i_gross_weight), .i_net_weight(i_net_weight),
      .i_microvolts(i_microvolts), .i_preset_tare_flag(i_preset_tare_flag),
      .i_overload(i_overload), .i_underload(i_underload),
      .i_stable(i_stable), .i_din_pin(i_din_pin),
      .i_dout_state(i_dout_state), .o_cmd_valid(o_cmd_valid),
      .o_cmd_code(o_cmd_code), .o_cmd_arg1(o_cmd_arg1),
      .o_cmd_arg2(o_cmd_arg2), .i_cmd_done(i_cmd_done),
      .i_cmd_result(i_cmd_result));

   core_model core_model_inst (.i_clk(i_clk), .i_rst(i_rst),
      .i_cmd_valid(o_cmd_valid), .i_cmd_code(o_cmd_code),
      .i_cmd_arg1(o_cmd_arg1), .i_cmd_arg2(o_cmd_arg2),
      .o_cmd_done(i_cmd_done), .o_cmd_result(i_cmd_result),
      .o_seen_code(seen_code), .o_seen_arg1(seen_arg1),
      .o_seen_arg2(seen_arg2));

   // free-running clock and a hang guard well above the expected run
   always #4 i_clk = ~i_clk;
   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 5000) begin
         fail_count++;
         print_verdict();
      end
   end

   task automatic check(input string name, input logic [31:0] exp,
                        input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask : check

   // one strobe cycle, then the ack is looked at in its only cycle
   task automatic reg_acc(input logic [15:0] a, input logic w,
                          input logic [15:0] d);
      @(posedge i_clk);
      i_reg_addr  <= a;
      i_reg_wdata <= d;
      i_reg_rd    <= ~w;
      i_reg_wr    <= w;
      @(posedge i_clk);
      i_reg_rd <= 1'b0;
      i_reg_wr <= 1'b0;
      #1;
      check("ack", 32'h1, {31'h0, o_reg_ack});
      got_data = o_reg_rdata;
      got_err  = o_reg_err;
   endtask : reg_acc

   // arguments go in before the code; then wait for the count to move
   // a known code keeps the block busy past the next write; an unknown
   // code is closed at once, so that write lands
   task automatic do_cmd(input logic [7:0] code, input logic [31:0] a1,
                         input logic busy);
      reg_acc(weigh_regs_pkg::ADDR_ARG1_HIGH, 1'b1, a1[31:16]);
      reg_acc(weigh_regs_pkg::ADDR_ARG1_LOW, 1'b1, a1[15:0]);
      reg_acc(weigh_regs_pkg::ADDR_ARG2_HIGH, 1'b1, 16'h0001);
      reg_acc(weigh_regs_pkg::ADDR_ARG2_LOW, 1'b1, {8'h00, code});
      reg_acc(weigh_regs_pkg::ADDR_CMD_CODE, 1'b1, {8'h00, code});
      reg_acc(weigh_regs_pkg::ADDR_ARG1_HIGH, 1'b1, 16'h0000);
      check("busy write err", {31'h0, busy}, {31'h0, got_err});
      cmd_count = cmd_count + 4'h1;
      for (int k = 0; k < 20 && got_data[3:0] !== cmd_count; k++) begin
         reg_acc(weigh_regs_pkg::ADDR_CMD_STATUS, 1'b0, 16'h0000);
      end
   endtask : do_cmd

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : print_verdict

   initial begin
      repeat (4) @(posedge i_clk);
      i_rst <= 1'b0;
      // first pattern: tare, underload, negative gross, second input
      i_preset_tare_flag <= 1'b1;
      i_underload    <= 1'b1;
      i_gross_weight <= 32'hFFFF_FC18;
      i_net_weight   <= 32'h0000_1234;
      i_din_pin      <= 2'b10;
      i_dout_state   <= 2'b01;
      i_microvolts   <= 16'h4E20;
      repeat (8) @(posedge i_clk);
      reg_acc(weigh_regs_pkg::ADDR_INPUT_STATUS, 1'b0, 16'h0000);
      check("status a", 32'h022A, got_data);
      reg_acc(weigh_regs_pkg::ADDR_GROSS_HIGH, 1'b0, 16'h0000);
      check("gross high", 32'hFFFF, got_data);
      reg_acc(weigh_regs_pkg::ADDR_GROSS_LOW, 1'b0, 16'h0000);
      check("gross low", 32'hFC18, got_data);
      reg_acc(weigh_regs_pkg::ADDR_NET_LOW, 1'b0, 16'h0000);
      check("net low", 32'h1234, got_data);
      reg_acc(weigh_regs_pkg::ADDR_MICROVOLTS, 1'b0, 16'h0000);
      check("microvolts", 32'h4E20, got_data);
      reg_acc(weigh_regs_pkg::ADDR_OUT_STATUS, 1'b0, 16'h0000);
      check("outputs a", 32'h0002, got_data);
      // second pattern flips every flag
      i_preset_tare_flag <= 1'b0;
      i_underload    <= 1'b0;
      i_overload     <= 1'b1;
      i_stable       <= 1'b1;
      i_gross_weight <= 32'h0000_03E8;
      i_net_weight   <= 32'h8000_0000;
      i_din_pin      <= 2'b01;
      i_dout_state   <= 2'b10;
      repeat (8) @(posedge i_clk);
      reg_acc(weigh_regs_pkg::ADDR_INPUT_STATUS, 1'b0, 16'h0000);
      check("status b", 32'h0115, got_data);
      reg_acc(weigh_regs_pkg::ADDR_OUT_STATUS, 1'b0, 16'h0000);
      check("outputs b", 32'h0001, got_data);
      // refusals: unmapped read, read-only write
      reg_acc(16'h7538, 1'b0, 16'h0000);
      check("unmapped err", 32'h1, {31'h0, got_err});
      check("unmapped data", 32'h0, got_data);
      reg_acc(weigh_regs_pkg::ADDR_INPUT_STATUS, 1'b1, 16'hFFFF);
      check("ro write err", 32'h1, {31'h0, got_err});
      // every documented nonzero code, then one unknown code
      foreach (codes[i]) begin
         do_cmd(codes[i], 32'h0000_03E8, i < 7);
         if (i < 7) begin
            check("cmd code", codes[i], seen_code);
            check("cmd arg1", 32'h0000_03E8, seen_arg1);
            check("cmd arg2", {24'h000100, codes[i]}, seen_arg2);
            check("cmd status", {codes[i], codes[i][3:0], cmd_count},
                  got_data);
         end else begin
            check("bad code status", {8'h55, 4'hF, cmd_count},
                  got_data);
         end
      end
      // code zero starts nothing: count stays put
      reg_acc(weigh_regs_pkg::ADDR_CMD_CODE, 1'b1, 16'h0000);
      check("idle write err", 32'h0, {31'h0, got_err});
      repeat (10) @(posedge i_clk);
      reg_acc(weigh_regs_pkg::ADDR_CMD_STATUS, 1'b0, 16'h0000);
      check("no command", {8'h55, 4'hF, cmd_count}, got_data);
      print_verdict();
   end
endmodule : testbench
